/* File: mic_regs.vh */
// Purpose: register indices, field positions, masks, vectors
// Assumes: included by the interrupt controller files
// Notes: register indices are select codes on the register port
`ifndef MIC_REGS_VH
`define MIC_REGS_VH

// Register select codes
`define MIC_IDX_EDGE 3'h0
`define MIC_IDX_CTRL_A 3'h1
`define MIC_IDX_CTRL_B 3'h2
`define MIC_IDX_TMR_A 3'h3
`define MIC_IDX_TMR_B 3'h4

// Variants
`define MIC_VAR_BASIC 2'h0
`define MIC_VAR_MULTI 2'h1
`define MIC_VAR_EXT 2'h2

// Control A fields
`define MIC_A_GIE 0
`define MIC_A_EXT0_EN 1
`define MIC_A_TB0_EN 2
`define MIC_A_TB1_EN 3
`define MIC_A_EXT0_F 4
`define MIC_A_TB0_F 5
`define MIC_A_TB1_F 6

// Control B fields
`define MIC_B_MF0_EN 0
`define MIC_B_EE_EN 1
`define MIC_B_ADC_EN 2
`define MIC_B_X_EN 3
`define MIC_B_MF0_F 4
`define MIC_B_EE_F 5
`define MIC_B_ADC_F 6
`define MIC_B_X_F 7

// Implemented-bit masks
`define MIC_MASK_CTRL_A 8'h7f
`define MIC_MASK_CTRL_B_BASIC 8'h77
`define MIC_MASK_FULL 8'hff
`define MIC_MASK_TMR_PAIR 8'h33
`define MIC_MASK_EDGE_ONE 8'h03
`define MIC_MASK_EDGE_TWO 8'h0f
`define MIC_MASK_FLAGS 8'hf0
`define MIC_RESET_VAL 8'h00

// Edge select codes
`define MIC_EDGE_OFF 2'h0
`define MIC_EDGE_RISE 2'h1
`define MIC_EDGE_FALL 2'h2
`define MIC_EDGE_BOTH 2'h3

// Source numbers in priority order, 0 highest
`define MIC_SRC_N 8
`define MIC_SRC_EXT0 3'h0
`define MIC_SRC_EXT1 3'h1
`define MIC_SRC_ADC 3'h2
`define MIC_SRC_MF0 3'h3
`define MIC_SRC_MF1 3'h4
`define MIC_SRC_TB0 3'h5
`define MIC_SRC_TB1 3'h6
`define MIC_SRC_EE 3'h7

// Program counter width and vector addresses
`define MIC_PC_W 11
`define MIC_VEC_EXT0 11'h004
`define MIC_VEC_EXT1 11'h008
`define MIC_VEC_ADC 11'h00c
`define MIC_VEC_MF0 11'h010
`define MIC_VEC_MF1 11'h014
`define MIC_VEC_TB0 11'h018
`define MIC_VEC_TB1 11'h01c
`define MIC_VEC_EE 11'h020

`endif

/* File: mic_ext_edge.v */
// Purpose: external pin synchroniser and edge detector
// Assumes: pin is asynchronous to CLK
// Notes: evt is a one-cycle pulse on the selected edge
`timescale 1ns/1ns
`include "mic_regs.vh"
module mic_ext_edge (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire pin,
  input wire [1:0] sel,
  output reg evt
);
  reg sync1_r;
  reg sync2_r;
  reg prev_r;
  wire rise;
  wire fall;
  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;
  always @(posedge clk) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (ce) begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  always @* begin
    case (sel)
      `MIC_EDGE_OFF: evt = 1'b0;
      `MIC_EDGE_RISE: evt = rise;
      `MIC_EDGE_FALL: evt = fall;
      `MIC_EDGE_BOTH: evt = rise | fall;
      default: evt = 1'b0;
    endcase
  end
endmodule

/* File: mic_irq_ctrl.v */
// Purpose: interrupt flags, enables, priority and vectoring
// Assumes: CPU strobes instruction boundaries and return
// Notes: VARIANT selects basic, second multi or second pin map
// Notes on behaviour
// - Basic control B: bits 7, 3 read zero
// - Multi variant: bit 7/3 multi1 flag, enable
// - Ext variant: bit 7/3 ext1 flag, enable
// - Flags 1 when pending; enables; reset zero
// - Single timer register: A/P flags, enables
// - Dual timer register: four flags, four enables
// - Second timer register for periodic timer
// - Events set their request flags
// - Vector only while individual enable high
// - Global enable low blocks every interrupt
// - Push program counter, load vector
// - Return pops saved program counter
// - Servicing clears global enable and the serviced flag
// - Full stack blocks acknowledge; flag stays
// - Fixed priority among simultaneous requests
// - Own vectors; timers share multi vector
// - Any flag rising wakes from sleep
// - Pin flag on selected edge type
// - Servicing pin clears its flag
// - Edge select: rise, fall, both, off
// - Edge code 00 off, 01, 10, 11
// - Multi service clears only group flag
// - Servicing converter clears its flag
`timescale 1ns/1ns
`include "mic_regs.vh"
module mic_irq_ctrl #(
  parameter VARIANT = 0
) (
  input wire CLK,
  input wire RESET,
  input wire CE,
  input wire [2:0] REG_ADDR,
  input wire REG_WR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  input wire [1:0] EXT_IRQ_PINS,
  input wire ADC_DONE,
  input wire EEPROM_WRITE_DONE,
  input wire TB0_EVT,
  input wire TB1_EVT,
  input wire [3:0] TIMER_EVT,
  input wire INSTR_BOUNDARY,
  input wire [`MIC_PC_W-1:0] PC_NEXT,
  input wire STACK_FULL,
  input wire RETI,
  output reg IRQ_TAKE,
  output reg [`MIC_PC_W-1:0] IRQ_VECTOR,
  output reg STACK_PUSH,
  output reg [`MIC_PC_W-1:0] PUSH_PC,
  output reg STACK_POP,
  output reg WAKE_UP
);
  // Implemented-bit masks per variant
  localparam V1 = (VARIANT == `MIC_VAR_MULTI);
  localparam V2 = (VARIANT == `MIC_VAR_EXT);
  localparam [7:0] MASK_A = `MIC_MASK_CTRL_A;
  localparam [7:0] MASK_B = (V1 || V2) ? `MIC_MASK_FULL :
    `MIC_MASK_CTRL_B_BASIC;
  localparam [7:0] MASK_TA = V2 ? `MIC_MASK_FULL :
    `MIC_MASK_TMR_PAIR;
  localparam [7:0] MASK_TB = V1 ? `MIC_MASK_TMR_PAIR :
    8'h00;
  localparam [7:0] MASK_E = V2 ? `MIC_MASK_EDGE_TWO :
    `MIC_MASK_EDGE_ONE;

  // State, next values and decode nets
  reg [7:0] edge_r;
  reg [7:0] ctrl_a_r;
  reg [7:0] ctrl_b_r;
  reg [7:0] tmr_a_r;
  reg [7:0] tmr_b_r;
  reg [7:0] edge_nxt;
  reg [7:0] ctrl_a_nxt;
  reg [7:0] ctrl_b_nxt;
  reg [7:0] tmr_a_nxt;
  reg [7:0] tmr_b_nxt;
  reg [7:0] set_a;
  reg [7:0] set_b;
  reg [7:0] set_ta;
  reg [7:0] set_tb;
  reg [7:0] clr_a;
  reg [7:0] clr_b;
  reg [7:0] pend;
  reg [2:0] src;
  reg found;
  reg [`MIC_PC_W-1:0] vec;
  reg mf0_evt;
  reg mf1_evt;
  reg take;
  reg [7:0] rdata_nxt;
  wire ext0_evt;
  wire ext1_evt;
  integer i;
  reg gate_open;

  // Wake-up detect
  reg [7:0] rise_a;
  reg [7:0] rise_b;
  reg [7:0] rise_ta;
  reg [7:0] rise_tb;
  reg wake_nxt;

  // Pin edge detectors
  mic_ext_edge u_edge0 (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .pin(EXT_IRQ_PINS[0]),
    .sel(edge_r[1:0]),
    .evt(ext0_evt)
  );

  mic_ext_edge u_edge1 (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .pin(EXT_IRQ_PINS[1]),
    .sel(edge_r[3:2]),
    .evt(ext1_evt)
  );

  // Hardware set vectors
  always @* begin
    if (V2) begin
      mf0_evt = |(TIMER_EVT & tmr_a_r[3:0]);
    end else begin
      mf0_evt = |(TIMER_EVT[1:0] & tmr_a_r[1:0]);
    end
    mf1_evt = V1 & (|(TIMER_EVT[3:2] & tmr_b_r[1:0]));
    set_a = 8'h00;
    set_a[`MIC_A_EXT0_F] = ext0_evt;
    set_a[`MIC_A_TB0_F] = TB0_EVT;
    set_a[`MIC_A_TB1_F] = TB1_EVT;
    set_b = 8'h00;
    set_b[`MIC_B_ADC_F] = ADC_DONE;
    set_b[`MIC_B_EE_F] = EEPROM_WRITE_DONE;
    set_b[`MIC_B_MF0_F] = mf0_evt;
    set_b[`MIC_B_X_F] = V2 ? ext1_evt : mf1_evt;
    if (V2) begin
      set_ta = {TIMER_EVT, 4'h0};
    end else begin
      set_ta = {2'b00, TIMER_EVT[1:0], 4'h0};
    end
    set_tb = V1 ? {2'b00, TIMER_EVT[3:2], 4'h0} : 8'h00;
  end

  // Pending enabled requests and priority pick
  always @* begin
    pend = 8'h00;
    pend[`MIC_SRC_EXT0] = ctrl_a_r[`MIC_A_EXT0_F] &
      ctrl_a_r[`MIC_A_EXT0_EN];
    pend[`MIC_SRC_EXT1] = V2 & ctrl_b_r[`MIC_B_X_F] &
      ctrl_b_r[`MIC_B_X_EN];
    pend[`MIC_SRC_ADC] = ctrl_b_r[`MIC_B_ADC_F] &
      ctrl_b_r[`MIC_B_ADC_EN];
    pend[`MIC_SRC_MF0] = ctrl_b_r[`MIC_B_MF0_F] &
      ctrl_b_r[`MIC_B_MF0_EN];
    pend[`MIC_SRC_MF1] = V1 & ctrl_b_r[`MIC_B_X_F] &
      ctrl_b_r[`MIC_B_X_EN];
    pend[`MIC_SRC_TB0] = ctrl_a_r[`MIC_A_TB0_F] &
      ctrl_a_r[`MIC_A_TB0_EN];
    pend[`MIC_SRC_TB1] = ctrl_a_r[`MIC_A_TB1_F] &
      ctrl_a_r[`MIC_A_TB1_EN];
    pend[`MIC_SRC_EE] = ctrl_b_r[`MIC_B_EE_F] &
      ctrl_b_r[`MIC_B_EE_EN];
    src = 3'h0;
    found = 1'b0;
    // Lowest source number wins
    for (i = `MIC_SRC_N - 1; i >= 0; i = i - 1) begin
      if (pend[i]) begin
        src = i[2:0];
        found = 1'b1;
      end
    end
    gate_open = INSTR_BOUNDARY & ctrl_a_r[`MIC_A_GIE] &
      ~STACK_FULL;
    take = gate_open & found;
  end

  // Vector and automatic clears of the serviced source
  always @* begin
    clr_a = 8'h00;
    clr_b = 8'h00;
    vec = `MIC_VEC_EXT0;
    if (take) begin
      clr_a[`MIC_A_GIE] = 1'b1;
      case (src)
        `MIC_SRC_EXT0: begin
          vec = `MIC_VEC_EXT0;
          clr_a[`MIC_A_EXT0_F] = 1'b1;
        end
        `MIC_SRC_EXT1: begin
          vec = `MIC_VEC_EXT1;
          clr_b[`MIC_B_X_F] = 1'b1;
        end
        `MIC_SRC_ADC: begin
          vec = `MIC_VEC_ADC;
          clr_b[`MIC_B_ADC_F] = 1'b1;
        end
        `MIC_SRC_MF0: begin
          vec = `MIC_VEC_MF0;
          clr_b[`MIC_B_MF0_F] = 1'b1;
        end
        `MIC_SRC_MF1: begin
          vec = `MIC_VEC_MF1;
          clr_b[`MIC_B_X_F] = 1'b1;
        end
        `MIC_SRC_TB0: begin
          vec = `MIC_VEC_TB0;
          clr_a[`MIC_A_TB0_F] = 1'b1;
        end
        `MIC_SRC_TB1: begin
          vec = `MIC_VEC_TB1;
          clr_a[`MIC_A_TB1_F] = 1'b1;
        end
        `MIC_SRC_EE: begin
          vec = `MIC_VEC_EE;
          clr_b[`MIC_B_EE_F] = 1'b1;
        end
        default: vec = `MIC_VEC_EXT0;
      endcase
    end
  end

  // Register next values; hardware set wins over any clear
  always @* begin
    edge_nxt = edge_r;
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    tmr_a_nxt = tmr_a_r;
    tmr_b_nxt = tmr_b_r;
    if (REG_WR) begin
      case (REG_ADDR)
        `MIC_IDX_EDGE: edge_nxt = REG_WDATA & MASK_E;
        `MIC_IDX_CTRL_A: ctrl_a_nxt = REG_WDATA & MASK_A;
        `MIC_IDX_CTRL_B: ctrl_b_nxt = REG_WDATA & MASK_B;
        `MIC_IDX_TMR_A: tmr_a_nxt = REG_WDATA & MASK_TA;
        `MIC_IDX_TMR_B: tmr_b_nxt = REG_WDATA & MASK_TB;
        default: edge_nxt = edge_r;
      endcase
    end
    ctrl_a_nxt = (ctrl_a_nxt & ~clr_a) | (set_a & MASK_A);
    ctrl_b_nxt = (ctrl_b_nxt & ~clr_b) | (set_b & MASK_B);
    tmr_a_nxt = tmr_a_nxt | (set_ta & MASK_TA);
    tmr_b_nxt = tmr_b_nxt | (set_tb & MASK_TB);
    // Read data, one cycle behind the address
    case (REG_ADDR)
      `MIC_IDX_EDGE: rdata_nxt = edge_r;
      `MIC_IDX_CTRL_A: rdata_nxt = ctrl_a_r;
      `MIC_IDX_CTRL_B: rdata_nxt = ctrl_b_r;
      `MIC_IDX_TMR_A: rdata_nxt = tmr_a_r;
      `MIC_IDX_TMR_B: rdata_nxt = tmr_b_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Flags rising 0 to 1, enables ignored
  always @* begin
    rise_a = ctrl_a_nxt & ~ctrl_a_r & `MIC_MASK_FLAGS;
    rise_b = ctrl_b_nxt & ~ctrl_b_r & `MIC_MASK_FLAGS;
    rise_ta = tmr_a_nxt & ~tmr_a_r & `MIC_MASK_FLAGS;
    rise_tb = tmr_b_nxt & ~tmr_b_r & `MIC_MASK_FLAGS;
    wake_nxt = |(rise_a | rise_b | rise_ta | rise_tb);
  end

  // State update; CE low freezes all
  always @(posedge CLK) begin
    if (RESET) begin
      edge_r <= `MIC_RESET_VAL;
      ctrl_a_r <= `MIC_RESET_VAL;
      ctrl_b_r <= `MIC_RESET_VAL;
      tmr_a_r <= `MIC_RESET_VAL;
      tmr_b_r <= `MIC_RESET_VAL;
      REG_RDATA <= 8'h00;
      IRQ_TAKE <= 1'b0;
      IRQ_VECTOR <= {`MIC_PC_W{1'b0}};
      STACK_PUSH <= 1'b0;
      PUSH_PC <= {`MIC_PC_W{1'b0}};
      STACK_POP <= 1'b0;
      WAKE_UP <= 1'b0;
    end else if (CE) begin
      edge_r <= edge_nxt;
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      tmr_a_r <= tmr_a_nxt;
      tmr_b_r <= tmr_b_nxt;
      REG_RDATA <= rdata_nxt;
      IRQ_TAKE <= take;
      STACK_PUSH <= take;
      STACK_POP <= RETI;
      if (take) begin
        IRQ_VECTOR <= vec;
        PUSH_PC <= PC_NEXT;
      end
      WAKE_UP <= wake_nxt;
    end
  end
endmodule

/* File: mic_irq_ctrl_chk.sv */
// Purpose: port checker for mic_irq_ctrl
// Assumes: CE held high
// Notes: bound at the foot
`timescale 1ns/1ns
module mic_irq_ctrl_chk (
  input wire CLK,
  input wire RESET,
  input wire [2:0] REG_ADDR,
  input wire [7:0] REG_RDATA,
  input wire INSTR_BOUNDARY,
  input wire [10:0] PC_NEXT,
  input wire STACK_FULL,
  input wire RETI,
  input wire IRQ_TAKE,
  input wire [10:0] IRQ_VECTOR,
  input wire STACK_PUSH,
  input wire [10:0] PUSH_PC,
  input wire STACK_POP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  a_take_boundary: assert property (
    IRQ_TAKE |-> $past(INSTR_BOUNDARY) && !$past(STACK_FULL))
    else $error("take off boundary or full");
  a_push_take: assert property (
    STACK_PUSH == IRQ_TAKE) else $error("push without take");
  a_push_pc: assert property (
    IRQ_TAKE |-> PUSH_PC == $past(PC_NEXT)) else $error("bad pushed pc");
  a_pop_echo: assert property (
    !$past(RESET) |-> STACK_POP == $past(RETI)) else $error("bad pop");
  a_no_nesting: assert property (
    IRQ_TAKE |=> !IRQ_TAKE [*2]) else $error("take while disabled");
  a_vector_legal: assert property (
    IRQ_TAKE |-> IRQ_VECTOR[1:0] == 2'h0 && IRQ_VECTOR >= 11'h004
    && IRQ_VECTOR <= 11'h020) else $error("bad vector");
  a_vector_hold: assert property (
    !IRQ_TAKE && !$past(RESET) |-> $stable(IRQ_VECTOR))
    else $error("vector moved");
  a_unimpl_zero: assert property (
    $past(REG_ADDR) > 3'h4 |-> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind mic_irq_ctrl mic_irq_ctrl_chk chk_u (.CLK(CLK), .RESET(RESET),
  .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .RETI(RETI),
  .INSTR_BOUNDARY(INSTR_BOUNDARY), .PC_NEXT(PC_NEXT), .PUSH_PC(PUSH_PC),
  .STACK_FULL(STACK_FULL), .IRQ_TAKE(IRQ_TAKE), .STACK_POP(STACK_POP),
  .IRQ_VECTOR(IRQ_VECTOR), .STACK_PUSH(STACK_PUSH));

/* File: mic_cpu_model.sv */
// Purpose: CPU side model, stack depth and return
// Assumes: one push per take, one pop per return
// Notes: returns some cycles after entry when allowed
`timescale 1ns/1ns
module mic_cpu_model #(
  parameter DEPTH = 2
) (
  input wire clk,
  input wire rst,
  input wire stack_push,
  input wire stack_pop,
  input wire ret_en,
  input wire slow,
  output reg boundary,
  output reg [10:0] pc_next,
  output wire stack_full,
  output reg reti
);
  reg [2:0] depth_r;
  reg [3:0] wait_r;
  assign stack_full = depth_r == DEPTH;
  always @(posedge clk) begin
    if (rst) begin
      depth_r <= 3'h0;
      wait_r <= 4'h0;
      reti <= 1'b0;
      boundary <= 1'b0;
      pc_next <= 11'h100;
    end else begin
      boundary <= slow ? ~boundary : 1'b1;
      if (boundary)
        pc_next <= pc_next + 11'h001;
      depth_r <= depth_r + {2'h0, stack_push} - {2'h0, stack_pop};
      reti <= ret_en && wait_r == 4'h8 && !reti;
      if (depth_r == 3'h0 || reti)
        wait_r <= 4'h0;
      else if (wait_r != 4'h8)
        wait_r <= wait_r + 4'h1;
    end
  end
endmodule

/* File: mic_irq_ctrl_test.sv */
// Purpose: self-checking bench for mic_irq_ctrl
// Assumes: VARIANT 2, stack depth 2
// Notes: takes are compared against a queue
`timescale 1ns/1ns
`include "mic_regs.vh"
module mic_irq_ctrl_test;
  reg clk = 0, rst = 1, we = 0, adc = 0, ee = 0, ret_en = 1, slow = 0;
  reg [2:0] addr = 0;
  reg [7:0] wdata = 0;
  reg [1:0] pins = 0;
  reg [3:0] tevt = 0;
  reg [1:0] tb = 0;
  reg [31:0] rnd = 32'd78708;
  reg [10:0] exp_q[$];
  wire [7:0] rdata;
  wire bnd, full, reti, take, push, pop, wake;
  wire [10:0] pcn, vec, ppc;
  integer num_errors = 0, checks = 0, i, p, c;
  always #20 clk = ~clk;
  mic_cpu_model cpu_u (.clk(clk), .rst(rst), .stack_push(push),
    .stack_pop(pop), .ret_en(ret_en), .slow(slow), .boundary(bnd),
    .pc_next(pcn), .stack_full(full), .reti(reti));
  mic_irq_ctrl #(.VARIANT(2)) dut_u (.CLK(clk), .RESET(rst), .CE(1'b1),
    .REG_ADDR(addr), .REG_WR(we), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .EXT_IRQ_PINS(pins), .ADC_DONE(adc), .EEPROM_WRITE_DONE(ee),
    .TB0_EVT(tb[0]), .TB1_EVT(tb[1]), .TIMER_EVT(tevt),
    .INSTR_BOUNDARY(bnd), .PC_NEXT(pcn), .STACK_FULL(full), .RETI(reti),
    .IRQ_TAKE(take), .IRQ_VECTOR(vec), .STACK_PUSH(push), .PUSH_PC(ppc),
    .STACK_POP(pop), .WAKE_UP(wake));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  task automatic check(input [10:0] got, input [10:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task wr(input [2:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task rd(input [2:0] a, input [7:0] e);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    @(negedge clk);
    check({3'h0, rdata}, {3'h0, e});
  endtask
  task pulse(input [1:0] s);
    @(posedge clk);
    adc <= s[0];
    ee <= s[1];
    @(posedge clk);
    adc <= 1'b0;
    ee <= 1'b0;
  endtask
  task wait_q;
    for (c = 0; c < 60 && exp_q.size() > 0; c = c + 1)
      @(posedge clk);
    if (exp_q.size() > 0) begin
      num_errors = num_errors + 1;
      complete_run;
    end
  endtask
  task go(input [10:0] v);
    exp_q.push_back(v);
    wr(3'h1, 8'h01);
    wait_q;
  endtask
  task edge_try(input integer k, input v, input f);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h00);
    pins[k] <= v;
    repeat (6) @(posedge clk);
    rd(k ? 3'h2 : 3'h1, f ? (k ? 8'h80 : 8'h10) : 8'h00);
  endtask
  always @(negedge clk) begin
    if (!rst && take === 1'b1) begin
      if (exp_q.size() == 0)
        check(vec, 11'h7ff);
      else
        check(vec, exp_q.pop_front());
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i = i + 1)
      rd(i[2:0], 8'h00);
    wr(3'h0, 8'hff);
    rd(3'h0, 8'h0f);
    wr(3'h1, 8'hfe);
    rd(3'h1, 8'h7e);
    for (i = 2; i < 5; i = i + 1) begin
      rnd = xs(rnd);
      wr(i[2:0], rnd[7:0]);
      rd(i[2:0], i == 4 ? 8'h00 : rnd[7:0]);
    end
    for (i = 0; i < 5; i = i + 1)
      wr(i[2:0], 8'h00);
    $display("test registers done");
    for (p = 0; p < 2; p = p + 1) begin
      for (i = 0; i < 4; i = i + 1) begin
        wr(3'h0, i[3:0] << (2 * p));
        edge_try(p, 1'b1, i[0]);
        edge_try(p, 1'b0, i[1]);
      end
    end
    $display("test edges done");
    pulse(2'h2);
    for (c = 0; c < 4 && wake !== 1'b1; c = c + 1)
      @(negedge clk);
    check({10'h0, wake}, 11'h001);
    wr(3'h2, 8'h04);
    @(negedge clk) check({10'h0, wake}, 11'h000);
    pulse(2'h1);
    go(`MIC_VEC_ADC);
    rd(3'h2, 8'h04);
    rd(3'h1, 8'h00);
    wr(3'h2, 8'h00);
    pulse(2'h1);
    wr(3'h1, 8'h01);
    repeat (10) @(posedge clk);
    rd(3'h2, 8'h40);
    $display("test take done");
    slow <= 1'b1;
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h06);
    pulse(2'h3);
    rd(3'h2, 8'h66);
    go(`MIC_VEC_ADC);
    go(`MIC_VEC_EE);
    wr(3'h3, 8'h01);
    wr(3'h2, 8'h01);
    @(posedge clk) tevt <= 4'h1;
    @(posedge clk) tevt <= 4'h0;
    go(`MIC_VEC_MF0);
    rd(3'h3, 8'h11);
    rd(3'h2, 8'h01);
    $display("test priority done");
    exp_q.push_back(`MIC_VEC_TB0);
    wr(3'h1, 8'h0d);
    @(posedge clk) tb <= 2'h3;
    @(posedge clk) tb <= 2'h0;
    wait_q;
    rd(3'h1, 8'h4c);
    exp_q.push_back(`MIC_VEC_TB1);
    wr(3'h1, 8'h4d);
    wait_q;
    rd(3'h1, 8'h0c);
    $display("test time base done");
    repeat (40) @(posedge clk);
    ret_en <= 1'b0;
    wr(3'h2, 8'h04);
    for (i = 0; i < 2; i = i + 1) begin
      pulse(2'h1);
      go(`MIC_VEC_ADC);
    end
    pulse(2'h1);
    wr(3'h1, 8'h01);
    repeat (10) @(posedge clk);
    rd(3'h2, 8'h44);
    exp_q.push_back(`MIC_VEC_ADC);
    ret_en <= 1'b1;
    wait_q;
    $display("test stack done");
    complete_run;
  end
endmodule
